// ===== logic/arj_format.sv
`timescale 1ns/1ps
`default_nettype none
module arj_format (
  // result and layout
  arj_res_if.fmt res
);
  // ---------------------------------------------------------------
  // byte layout per justification mode
  // ---------------------------------------------------------------
  always_comb begin
    res.trunc = res.result[9:2];
    unique case (arj_pkg::arj_mode_e'(res.mode))
      arj_pkg::ARJ_TRUNC: begin
        res.high = 8'h00;
        res.low  = res.result[9:2];
      end
      arj_pkg::ARJ_RIGHT: begin
        res.high = {6'h00, res.result[9:8]};
        res.low  = res.result[7:0];
      end
      arj_pkg::ARJ_LEFT: begin
        res.high = res.result[9:2];
        res.low  = {res.result[1:0], 6'h00};
      end
      arj_pkg::ARJ_LEFT_S: begin
        res.high = {~res.result[9], res.result[8:2]};
        res.low  = {res.result[1:0], 6'h00};
      end
    endcase
  end
endmodule : arj_format
`default_nettype wire

// ===== logic/arj_result_regs.sv
`timescale 1ns/1ps
`default_nettype none
// Function
// - result shown as high and low byte pair
// - truncated: low gets bits 9-2, high zero
// - truncated: low overwritten every channel 0 conversion, no interlock
// - right: high bits 1-0 hold bits 9-8, low bits 7-0
// - 10-bit modes update both bytes per channel 0 conversion
// - high read freezes low until low read
// - left: high holds bits 9 to 2
// - left modes: low bits 7-6 hold bits 1-0
// - signed left: invert top bit in high byte
// - scan truncated: channels 1-3 own low bytes
// - scan count picks channels 0 to N
// - scan enable bit, reset clears it
// - mode field decode, reset selects right
// - any low byte read clears complete flag
// - interrupt on done, cleared by reads/writes
module arj_result_regs (
  // clock and reset
  input  wire logic       sys_clk,
  input  wire logic       srst,
  // converter core
  input  wire logic [9:0] conv_result,
  input  wire logic       conv_done,
  // register port
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic [7:0]      reg_rdata,
  // core control
  output logic [1:0]      scan_chan,
  output logic            scan_enable,
  output logic            cont_conv,
  // interrupt
  output logic            irq
);
  // ---------------------------------------------------------------
  // declarations
  // ---------------------------------------------------------------
  arj_res_if res ();
  logic [7:0] high_r;
  logic [7:0] low_r;
  logic [7:0] scan_low_r [1:3];
  logic [1:0] scan_cnt_r;
  logic       scan_en_r;
  logic [1:0] mode_r;
  logic       cont_r;
  logic       irq_en_r;
  logic       conversion_complete_flag_r;
  logic       frozen_r;
  logic       conv_irq_r;
  logic [1:0] ev_stat_r;
  logic [1:0] ev_mask_r;
  logic [7:0] rdata_r;
  logic [7:0] rdata_nxt;
  logic [1:0] chan;
  logic       rd_high;
  logic       rd_low0;
  logic       rd_any_low;
  logic       wr_mode;
  logic       ten_bit;
  logic       take0;
  logic       lost;
  logic [1:0] ev_set;

  // ---------------------------------------------------------------
  // submodules
  // ---------------------------------------------------------------
  assign res.result = conv_result;
  assign res.mode   = mode_r;

  arj_format u_format (
    .res (res.fmt)
  );

  arj_scan_seq u_scan (
    .sys_clk   (sys_clk),
    .srst      (srst),
    .scan_en   (scan_en_r),
    .scan_cnt  (scan_cnt_r),
    .conv_done (conv_done),
    .chan      (chan)
  );

  // ---------------------------------------------------------------
  // access decode
  // ---------------------------------------------------------------
  assign rd_high    = reg_rd && (reg_addr == arj_pkg::OFS_RESULT_HIGH_BYTE);
  assign rd_low0    = reg_rd && (reg_addr == arj_pkg::OFS_RESULT_LOW_BYTE);
  assign rd_any_low = reg_rd && (reg_addr >= arj_pkg::OFS_RESULT_LOW_BYTE)
                      && (reg_addr <= arj_pkg::OFS_SCAN_RESULT_3);
  assign wr_mode    = reg_wr && (reg_addr == arj_pkg::OFS_MODE_CONTROL);
  assign ten_bit    = (mode_r != 2'(arj_pkg::ARJ_TRUNC));
  // channel 0 (or single channel) result lands in the pair
  assign take0      = conv_done && (!scan_en_r || chan == 2'h0);
  // 10-bit result dropped while low byte is frozen
  // a high read in the same cycle already holds the pair
  assign lost       = take0 && ten_bit && (frozen_r || rd_high);
  assign ev_set     = {lost, conv_done};

  // ---------------------------------------------------------------
  // result pair
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      high_r <= arj_pkg::RST_BYTE;
      low_r  <= arj_pkg::RST_BYTE;
    end else if (take0 && !ten_bit) begin
      high_r <= res.high;
      low_r  <= res.low;
    end else if (take0 && !frozen_r && !rd_high) begin
      high_r <= res.high;
      low_r  <= res.low;
    end
  end

  // freeze after high read, released by low read
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      frozen_r <= 1'b0;
    end else if (!ten_bit) begin
      frozen_r <= 1'b0;
    end else if (rd_low0) begin
      frozen_r <= 1'b0;
    end else if (rd_high) begin
      frozen_r <= 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // auto-scan truncated results, channels 1 to 3
  // ---------------------------------------------------------------
  genvar g;
  generate
    for (g = 1; g <= 3; g++) begin : g_scan
      always_ff @(posedge sys_clk) begin
        if (srst) begin
          scan_low_r[g] <= arj_pkg::RST_BYTE;
        end else if (conv_done && scan_en_r && !ten_bit && chan == 2'(g)) begin
          scan_low_r[g] <= res.trunc;
        end
      end
    end
  endgenerate

  // ---------------------------------------------------------------
  // control registers
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      scan_cnt_r <= arj_pkg::RST_SCAN_CNT;
      scan_en_r  <= 1'b0;
    end else if (reg_wr && reg_addr == arj_pkg::OFS_SCAN_CONTROL) begin
      scan_cnt_r <= reg_wdata[arj_pkg::SCAN_COUNT_LSB +: 2];
      scan_en_r  <= reg_wdata[arj_pkg::SCAN_ENABLE_BIT];
    end
  end

  // mode, continuous and interrupt-enable bits
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      mode_r   <= arj_pkg::RST_MODE;
      cont_r   <= 1'b0;
      irq_en_r <= 1'b0;
    end else if (wr_mode) begin
      mode_r   <= reg_wdata[arj_pkg::MODE_LSB +: 2];
      cont_r   <= reg_wdata[arj_pkg::CONT_CONV_BIT];
      irq_en_r <= reg_wdata[arj_pkg::IRQ_EN_BIT];
    end
  end

  // ---------------------------------------------------------------
  // completion flag and conversion interrupt
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      conversion_complete_flag_r <= 1'b0;
    end else if (conv_done) begin
      conversion_complete_flag_r <= 1'b1;                                               // set wins
    end else if (rd_any_low || wr_mode) begin
      conversion_complete_flag_r <= 1'b0;
    end
  end

  // conversion interrupt line
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      conv_irq_r <= 1'b0;
    end else if (conv_done && irq_en_r) begin
      conv_irq_r <= 1'b1;
    end else if (rd_low0 || rd_high || wr_mode) begin
      conv_irq_r <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // event status and mask
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      ev_stat_r <= arj_pkg::RST_IRQ;
    end else if (reg_rd && reg_addr == arj_pkg::OFS_IRQ_STATUS) begin
      ev_stat_r <= ev_set;                                          // set wins over read clear
    end else begin
      ev_stat_r <= ev_stat_r | ev_set;
    end
  end

  // mask register
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      ev_mask_r <= arj_pkg::RST_IRQ;
    end else if (reg_wr && reg_addr == arj_pkg::OFS_IRQ_MASK) begin
      ev_mask_r <= reg_wdata[1:0];
    end
  end

  assign irq = conv_irq_r || |(ev_stat_r & ev_mask_r);

  // ---------------------------------------------------------------
  // read data, one cycle after the strobe
  // ---------------------------------------------------------------
  always_comb begin
    rdata_nxt = 8'h00;
    unique case (reg_addr)
      arj_pkg::OFS_RESULT_HIGH_BYTE: rdata_nxt = high_r;
      arj_pkg::OFS_RESULT_LOW_BYTE:  rdata_nxt = low_r;
      arj_pkg::OFS_SCAN_RESULT_1:    rdata_nxt = scan_low_r[1];
      arj_pkg::OFS_SCAN_RESULT_2:    rdata_nxt = scan_low_r[2];
      arj_pkg::OFS_SCAN_RESULT_3:    rdata_nxt = scan_low_r[3];
      arj_pkg::OFS_SCAN_CONTROL:     rdata_nxt = {5'h00, scan_en_r, scan_cnt_r};
      arj_pkg::OFS_MODE_CONTROL:     rdata_nxt = {3'h0, conversion_complete_flag_r && !irq_en_r, irq_en_r, cont_r, mode_r};
      arj_pkg::OFS_IRQ_STATUS:       rdata_nxt = {6'h00, ev_stat_r};
      arj_pkg::OFS_IRQ_MASK:         rdata_nxt = {6'h00, ev_mask_r};
      default:                       rdata_nxt = 8'h00;             // unmapped
    endcase
  end

  // read data register, holds zero when no read
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      rdata_r <= 8'h00;
    end else begin
      rdata_r <= reg_rd ? rdata_nxt : 8'h00;
    end
  end

  assign reg_rdata   = rdata_r;
  assign scan_chan   = scan_en_r ? chan : 2'h0;
  assign scan_enable = scan_en_r;
  assign cont_conv   = cont_r;
endmodule : arj_result_regs
`default_nettype wire

// ===== logic/arj_scan_seq.sv
`timescale 1ns/1ps
`default_nettype none
module arj_scan_seq (
  // clock and reset
  input  wire logic       sys_clk,
  input  wire logic       srst,
  // control
  input  wire logic       scan_en,
  input  wire logic [1:0] scan_cnt,
  input  wire logic       conv_done,
  // current channel
  output logic [1:0]      chan
);
  logic [1:0] chan_r;
  logic [1:0] chan_nxt;

  // ---------------------------------------------------------------
  // ascending channel walk, wraps after the last selected channel
  // ---------------------------------------------------------------
  always_comb begin
    chan_nxt = chan_r;
    if (!scan_en) begin
      chan_nxt = 2'h0;
    end else if (conv_done) begin
      chan_nxt = (chan_r >= scan_cnt) ? 2'h0 : chan_r + 2'h1;
    end
  end

  // channel register
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      chan_r <= 2'h0;
    end else begin
      chan_r <= chan_nxt;
    end
  end

  assign chan = chan_r;
endmodule : arj_scan_seq
`default_nettype wire

// ===== shared/arj_pkg.sv
`default_nettype none
package arj_pkg;
  // ---------------------------------------------------------------
  // register offsets (byte addresses)
  // ---------------------------------------------------------------
  localparam logic [7:0] OFS_RESULT_HIGH_BYTE = 8'h59;
  localparam logic [7:0] OFS_RESULT_LOW_BYTE  = 8'h5A;
  localparam logic [7:0] OFS_SCAN_RESULT_1    = 8'h5B;
  localparam logic [7:0] OFS_SCAN_RESULT_2    = 8'h5C;
  localparam logic [7:0] OFS_SCAN_RESULT_3    = 8'h5D;
  localparam logic [7:0] OFS_SCAN_CONTROL     = 8'h5E;
  localparam logic [7:0] OFS_MODE_CONTROL     = 8'h60;
  localparam logic [7:0] OFS_IRQ_STATUS       = 8'h61;
  localparam logic [7:0] OFS_IRQ_MASK         = 8'h62;

  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int SCAN_COUNT_LSB  = 0;   // scan_control[1:0]
  localparam int SCAN_ENABLE_BIT = 2;   // scan_control[2]
  localparam int MODE_LSB        = 0;   // mode_control[1:0]
  localparam int CONT_CONV_BIT   = 2;   // mode_control[2]
  localparam int IRQ_EN_BIT      = 3;   // mode_control[3]
  localparam int EV_DONE_BIT     = 0;   // irq status: conversion done
  localparam int EV_LOST_BIT     = 1;   // irq status: result discarded

  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [7:0] RST_BYTE     = 8'h00;
  localparam logic [1:0] RST_MODE     = 2'h1;
  localparam logic [1:0] RST_SCAN_CNT = 2'h0;
  localparam logic [1:0] RST_IRQ      = 2'h0;

  // ---------------------------------------------------------------
  // justification modes
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    ARJ_TRUNC  = 2'b00,
    ARJ_RIGHT  = 2'b01,
    ARJ_LEFT   = 2'b10,
    ARJ_LEFT_S = 2'b11
  } arj_mode_e;
endpackage : arj_pkg
`default_nettype wire

// ===== shared/arj_res_if.sv
`timescale 1ns/1ps
`default_nettype none
// result path between core side and formatter
interface arj_res_if;
  logic [9:0] result;
  logic [1:0] mode;
  logic [7:0] high;
  logic [7:0] low;
  logic [7:0] trunc;
  modport fmt (input result, input mode, output high, output low, output trunc);
  modport user (output result, output mode, input high, input low, input trunc);
endinterface : arj_res_if
`default_nettype wire

// ===== test/arj_checker_sva.sv
`timescale 1ns/1ps
`default_nettype none
module arj_checker (
  // clock and reset
  input wire logic       sys_clk,
  input wire logic       srst,
  // core and register port
  input wire logic       conv_done,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  // outputs
  input wire logic [1:0] scan_chan,
  input wire logic       scan_enable,
  input wire logic       irq
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (srst);
  logic [1:0] mode_r;
  logic [1:0] cnt_r;
  // shadow of mode and scan count fields
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      mode_r <= arj_pkg::RST_MODE;
      cnt_r  <= arj_pkg::RST_SCAN_CNT;
    end else if (reg_wr && reg_addr == 8'h60) begin
      mode_r <= reg_wdata[1:0];
    end else if (reg_wr && reg_addr == 8'h5E) begin
      cnt_r <= reg_wdata[1:0];
    end
  end
  a_rdata_idle_zero: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("rdata not zero");
  a_trunc_high_zero: assert property (reg_rd && reg_addr == 8'h59 && mode_r == 2'h0 |=> reg_rdata == 8'h00)
    else $error("high not zero");
  a_right_high_top: assert property (reg_rd && reg_addr == 8'h59 && mode_r == 2'h1 |=> reg_rdata[7:2] == 6'h00)
    else $error("high top bits set");
  a_left_low_zero: assert property (reg_rd && reg_addr == 8'h5A && mode_r[1] |=> reg_rdata[5:0] == 6'h00)
    else $error("low bits set");
  a_scan_en_write: assert property (reg_wr && reg_addr == 8'h5E |=> scan_enable == $past(reg_wdata[2]))
    else $error("scan enable wrong");
  a_chan_step_up: assert property (conv_done && scan_enable && !reg_wr && scan_chan < cnt_r
    |=> scan_chan == $past(scan_chan) + 2'h1)
    else $error("channel not advanced");
  a_chan_wrap_zero: assert property (conv_done && scan_enable && !reg_wr && scan_chan >= cnt_r
    |=> scan_chan == 2'h0)
    else $error("channel not wrapped");
  a_irq_has_cause: assert property ($rose(irq)
    |-> $past(conv_done) || $past(conv_done, 2) || $past(reg_wr) || $past(reg_wr, 2))
    else $error("irq without cause");
  c_pair_read: cover property (reg_rd && reg_addr == 8'h59 ##2 reg_rd && reg_addr == 8'h5A);
  c_scan_wrap: cover property (conv_done && scan_enable && scan_chan == 2'h3);
  c_irq_rise: cover property ($rose(irq));
endmodule : arj_checker
bind arj_result_regs arj_checker u_chk (.sys_clk(sys_clk), .srst(srst), .conv_done(conv_done),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .scan_chan(scan_chan), .scan_enable(scan_enable), .irq(irq));
`default_nettype wire

// ===== test/arj_core_model.sv
`timescale 1ns/1ps
`default_nettype none
module arj_core_model (
  // clock and reset
  input  wire logic       sys_clk,
  input  wire logic       srst,
  // request
  input  wire logic       start,
  input  wire logic [9:0] value,
  input  wire logic [2:0] lat,
  // result
  output logic [9:0]      conv_result,
  output logic            conv_done
);
  logic [2:0] wait_r;
  // countdown, one-cycle done, junk result outside it
  always_ff @(posedge sys_clk) begin
    conv_done   <= 1'b0;
    conv_result <= conv_result ^ 10'h3FF;
    if (srst) begin
      wait_r      <= 3'h0;
      conv_result <= 10'h155;
    end else if (start) begin
      wait_r <= lat;
    end else if (wait_r != 3'h0) begin
      wait_r <= wait_r - 3'h1;
      if (wait_r == 3'h1) begin
        conv_done   <= 1'b1;
        conv_result <= value;
      end
    end
  end
endmodule : arj_core_model
`default_nettype wire

// ===== test/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic        sys_clk = 1'b0, srst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, start = 1'b0, rd_d = 1'b0;
  logic        conv_done, scan_enable, cont_conv, irq;
  logic [7:0]  reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
  logic [9:0]  cval = 10'h000, conv_result;
  logic [9:0]  v[4];
  logic [1:0]  scan_chan;
  logic [2:0]  lat = 3'h1;
  logic [15:0] exp_q[$];
  logic [15:0] note;
  logic [31:0] seed = 32'd38760;
  int          num_errors = 0, compares = 0, cycles = 0;
  arj_result_regs dut (.sys_clk(sys_clk), .srst(srst), .conv_result(conv_result), .conv_done(conv_done),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .scan_chan(scan_chan), .scan_enable(scan_enable), .cont_conv(cont_conv), .irq(irq));
  arj_core_model core (.sys_clk(sys_clk), .srst(srst), .start(start), .value(cval), .lat(lat),
    .conv_result(conv_result), .conv_done(conv_done));
  initial begin
    forever #2.5 sys_clk = ~sys_clk;
  end
  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic [9:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed[9:0];
  endfunction : xs
  function automatic logic [7:0] hi_of(input logic [1:0] m, input logic [9:0] r);
    return (m == 2'h0) ? 8'h00 : (m == 2'h1) ? {6'h00, r[9:8]} : {r[9] ^ m[0], r[8:2]};
  endfunction : hi_of
  function automatic logic [7:0] lo_of(input logic [1:0] m, input logic [9:0] r);
    return (m == 2'h0) ? r[9:2] : (m == 2'h1) ? r[7:0] : {r[1:0], 6'h00};
  endfunction : lo_of
  task automatic chk(input string what, input logic [7:0] e, input logic [7:0] s);
    compares++;
    if (s !== e) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", what, e, s);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge sys_clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    exp_q.push_back({a, e});
    @(posedge sys_clk);
    reg_rd <= 1'b0;
  endtask : rd
  task automatic conv(input logic [9:0] val);
    logic [9:0] r;
    r = xs();
    @(posedge sys_clk);
    start <= 1'b1;
    cval  <= val;
    lat   <= {1'b0, r[1:0]} + 3'h1;
    @(posedge sys_clk);
    start <= 1'b0;
    for (int i = 0; i < 20 && conv_done !== 1'b1; i++) @(posedge sys_clk);
    @(posedge sys_clk);
  endtask : conv
  task automatic irq_is(input logic e);
    @(posedge sys_clk);
    chk("irq", {7'h00, e}, {7'h00, irq});
  endtask : irq_is
  task automatic wrap_up();
    $display("num_errors %0d compares %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : wrap_up
  // read data checked against the oldest note
  always @(posedge sys_clk) begin
    if (rd_d) begin
      note = exp_q.pop_front();
      chk($sformatf("rdata_%h", note[15:8]), note[7:0], reg_rdata);
    end
    rd_d <= reg_rd;
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      wrap_up();
    end
  end
  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    repeat (20) @(posedge sys_clk);
    srst <= 1'b0;
    rd(8'h59, 8'h00);
    rd(8'h5E, 8'h00);
    rd(8'h60, 8'h01);
    rd(8'h7F, 8'h00);
    // every layout, flag cleared by the low read
    for (int m = 0; m < 4; m++) begin
      v[0] = xs();
      wr(8'h60, 8'(m));
      conv(v[0]);
      rd(8'h60, 8'h10 | 8'(m));
      rd(8'h59, hi_of(2'(m), v[0]));
      rd(8'h5A, lo_of(2'(m), v[0]));
      rd(8'h60, 8'(m));
    end
    // high read freezes the low byte
    v[1] = xs();
    v[2] = xs();
    wr(8'h60, 8'h01);
    rd(8'h61, 8'h01);
    conv(v[0]);
    rd(8'h59, {6'h00, v[0][9:8]});
    conv(v[1]);
    rd(8'h5A, v[0][7:0]);
    rd(8'h61, 8'h03);
    conv(v[2]);
    rd(8'h59, {6'h00, v[2][9:8]});
    rd(8'h5A, v[2][7:0]);
    // truncated low byte has no interlock
    wr(8'h60, 8'h00);
    conv(v[0]);
    rd(8'h59, 8'h00);
    conv(v[1]);
    rd(8'h5A, v[1][9:2]);
    // event status, mask (a set bit enables), conversion interrupt
    wr(8'h62, 8'h00);
    rd(8'h61, 8'h01);
    conv(v[2]);
    irq_is(1'b0);
    wr(8'h62, 8'hFF);
    irq_is(1'b1);
    rd(8'h62, 8'h03);
    rd(8'h61, 8'h01);
    irq_is(1'b0);
    wr(8'h62, 8'h00);
    wr(8'h60, 8'h08);
    conv(v[0]);
    irq_is(1'b1);
    rd(8'h60, 8'h08);
    rd(8'h5A, v[0][9:2]);
    irq_is(1'b0);
    conv(v[1]);
    irq_is(1'b1);
    rd(8'h59, 8'h00);
    irq_is(1'b0);
    conv(v[1]);
    wr(8'h60, 8'h04);
    irq_is(1'b0);
    chk("cont_conv", 8'h01, {7'h00, cont_conv});
    wr(8'h60, 8'h00);
    // auto-scan over every channel count
    for (int c = 0; c < 4; c++) begin
      wr(8'h5E, 8'h04 | 8'(c));
      rd(8'h5E, 8'h04 | 8'(c));
      for (int k = 0; k <= c; k++) begin
        v[k] = xs();
        chk("scan_chan", 8'(k), {6'h00, scan_chan});
        conv(v[k]);
      end
      chk("scan_chan", 8'h00, {6'h00, scan_chan});
      for (int k = 0; k <= c; k++) rd((k == 0) ? 8'h5A : 8'h5A + 8'(k), v[k][9:2]);
      wr(8'h5E, 8'h00);
    end
    repeat (3) @(posedge sys_clk);
    wrap_up();
  end
endmodule : tb
`default_nettype wire
